// file: shared/mepp_map.vh
`ifndef MEPP_MAP_VH
`define MEPP_MAP_VH

// System clock and management clock timing
`define MEPP_SYS_PERIOD_NS   100
`define MEPP_MDC_HALF_NS     400
`define MEPP_MDC_HALF_CYC    (`MEPP_MDC_HALF_NS / `MEPP_SYS_PERIOD_NS)

// Positions inside the synchronised per-channel pin vector
`define MEPP_S_WIDTH         10
`define MEPP_S_RXCLK         0
`define MEPP_S_TXCLK         1
`define MEPP_S_NIB_LO        2
`define MEPP_S_DV            6
`define MEPP_S_ERR           7
`define MEPP_S_CRS           8
`define MEPP_S_COL           9

// Transmit sequencer states, one-hot
`define MEPP_TS_IDLE         3'h1
`define MEPP_TS_LOW          3'h2
`define MEPP_TS_HIGH         3'h4

// Management sequencer states, one-hot
`define MEPP_MS_IDLE         2'h1
`define MEPP_MS_RUN          2'h2

// Management frame layout, bit index counted from the first preamble bit
`define MEPP_MG_PRE_BITS     6'h20
`define MEPP_MG_TA_BIT       6'h2e
`define MEPP_MG_DATA_BIT     6'h30
`define MEPP_MG_LAST_BIT     6'h3f
`define MEPP_MG_START        2'h1
`define MEPP_MG_OP_READ      2'h2
`define MEPP_MG_OP_WRITE     2'h1
`define MEPP_MG_TURN         2'h2

// Reset values
`define MEPP_RST_NIB         4'h0
`define MEPP_RST_BYTE        8'h00
`define MEPP_RST_WORD16      16'h0000
`define MEPP_RST_MDO         1'b1

`endif

// file: src/mepp_sync.v
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a bit only moves once stages two and three agree
module mepp_sync #(
	parameter W = 1
) (
	input  wire         clk_sys,
	input  wire         reset_n,
	input  wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	reg [W-1:0] filt_q;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1_q   <= {W{1'b0}};
			s2_q   <= {W{1'b0}};
			s3_q   <= {W{1'b0}};
			filt_q <= {W{1'b0}};
		end else begin
			s1_q   <= d_in;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
		end
	end

	assign q_out = filt_q;

endmodule // mepp_sync

`default_nettype wire

// file: src/mepp_top.v
`timescale 1ns/1ps
`default_nettype none
`include "mepp_map.vh"

module mepp_top (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire        eth0_collision_in,
	input  wire        eth0_carrier_in,
	input  wire        eth0_rx_clock,
	input  wire [3:0]  eth0_rx_nibble,
	input  wire        eth0_rx_valid,
	input  wire        eth0_rx_error,
	input  wire        eth0_tx_clock,
	output wire [3:0]  eth0_tx_nibble,
	output wire        eth0_tx_enable,
	output wire        eth0_tx_code_error,
	input  wire        eth1_collision_in,
	input  wire        eth1_carrier_in,
	input  wire        eth1_rx_clock,
	input  wire [3:0]  eth1_rx_nibble,
	input  wire        eth1_rx_valid,
	input  wire        eth1_rx_error,
	input  wire        eth1_tx_clock,
	output wire [3:0]  eth1_tx_nibble,
	output wire        eth1_tx_enable,
	output wire        eth1_tx_code_error,
	output wire [7:0]  eth0_rx_byte,
	output wire        eth0_rx_byte_valid,
	output wire        eth0_rx_frame_end,
	output wire        eth0_rx_frame_bad,
	input  wire [7:0]  eth0_tx_byte,
	input  wire        eth0_tx_byte_valid,
	input  wire        eth0_tx_byte_bad,
	output wire        eth0_tx_byte_ready,
	output wire        eth0_collision,
	output wire        eth0_carrier,
	output wire [7:0]  eth1_rx_byte,
	output wire        eth1_rx_byte_valid,
	output wire        eth1_rx_frame_end,
	output wire        eth1_rx_frame_bad,
	input  wire [7:0]  eth1_tx_byte,
	input  wire        eth1_tx_byte_valid,
	input  wire        eth1_tx_byte_bad,
	output wire        eth1_tx_byte_ready,
	output wire        eth1_collision,
	output wire        eth1_carrier,
	output wire        phy_mgmt_clock,
	input  wire        phy_mgmt_data_in,
	output wire        phy_mgmt_data_out,
	output wire        phy_mgmt_data_oe_n,
	input  wire        mgmt_start,
	input  wire        mgmt_read,
	input  wire [4:0]  mgmt_phy_addr,
	input  wire [4:0]  mgmt_reg_addr,
	input  wire [15:0] mgmt_wdata,
	output wire        mgmt_busy,
	output wire        mgmt_done,
	output wire [15:0] mgmt_rdata
);

	wire [19:0] pin_raw;
	wire [15:0] txb_in;
	wire [1:0]  txv_in;
	wire [1:0]  txe_in;

	assign pin_raw = {eth1_collision_in, eth1_carrier_in, eth1_rx_error,
		eth1_rx_valid, eth1_rx_nibble, eth1_tx_clock, eth1_rx_clock,
		eth0_collision_in, eth0_carrier_in, eth0_rx_error,
		eth0_rx_valid, eth0_rx_nibble, eth0_tx_clock, eth0_rx_clock};
	assign txb_in = {eth1_tx_byte, eth0_tx_byte};
	assign txv_in = {eth1_tx_byte_valid, eth0_tx_byte_valid};
	assign txe_in = {eth1_tx_byte_bad, eth0_tx_byte_bad};

	////////////////////////////////////////////////////////////////////////
	// Ethernet channels
	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_ch
			wire [9:0] s;
			wire       rx_fall;
			wire       tx_rise;
			wire       take;
			wire       load;
			reg        hfull_d;
			reg        rxc_q, txc_q, col_q, crs_q;
			reg        dv_q, half_q, bad_q, bvalid_q, end_q, fbad_q;
			reg  [3:0] lo_q;
			reg  [7:0] byte_q;
			reg  [7:0] hold_q;
			reg        hbad_q, hfull_q, ready_q;
			reg  [3:0] hi_q;
			reg        cbad_q;
			reg  [2:0] ts_q;
			reg  [3:0] nib_q;
			reg        en_q, er_q;

			mepp_sync #(
				.W(`MEPP_S_WIDTH)
			) u_sync (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.d_in    (pin_raw[i*10 +: 10]),
				.q_out   (s)
			);

			// sample on the falling receive edge, mid-nibble
			assign rx_fall = rxc_q & ~s[`MEPP_S_RXCLK];
			// launch just after the rising transmit edge
			assign tx_rise = ~txc_q & s[`MEPP_S_TXCLK];
			assign take    = txv_in[i] & ready_q;
			assign load    = tx_rise & hfull_q & ~ts_q[1];

			always @* begin
				hfull_d = hfull_q;
				if (take)
					hfull_d = 1'b1;
				else if (load)
					hfull_d = 1'b0;
			end

			always @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					rxc_q    <= 1'b0;
					txc_q    <= 1'b0;
					col_q    <= 1'b0;
					crs_q    <= 1'b0;
					dv_q     <= 1'b0;
					half_q   <= 1'b0;
					bad_q    <= 1'b0;
					bvalid_q <= 1'b0;
					end_q    <= 1'b0;
					fbad_q   <= 1'b0;
					lo_q     <= `MEPP_RST_NIB;
					byte_q   <= `MEPP_RST_BYTE;
				end else begin
					rxc_q    <= s[`MEPP_S_RXCLK];
					txc_q    <= s[`MEPP_S_TXCLK];
					col_q    <= s[`MEPP_S_COL];
					crs_q    <= s[`MEPP_S_CRS];
					bvalid_q <= 1'b0;
					end_q    <= 1'b0;
					if (rx_fall) begin
						dv_q <= s[`MEPP_S_DV];
						if (s[`MEPP_S_DV]) begin
							if (!half_q) begin
								lo_q   <= s[`MEPP_S_NIB_LO +: 4];
								half_q <= 1'b1;
							end else begin
								byte_q   <= {s[`MEPP_S_NIB_LO +: 4], lo_q};
								bvalid_q <= 1'b1;
								half_q   <= 1'b0;
							end
							if (s[`MEPP_S_ERR])
								bad_q <= 1'b1;
						end else begin
							// Odd trailing nibble is dropped here
							half_q <= 1'b0;
							if (dv_q) begin
								end_q  <= 1'b1;
								fbad_q <= bad_q;
								bad_q  <= 1'b0;
							end
						end
					end
				end
			end

			always @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					hold_q  <= `MEPP_RST_BYTE;
					hbad_q  <= 1'b0;
					hfull_q <= 1'b0;
					ready_q <= 1'b0;
					hi_q    <= `MEPP_RST_NIB;
					cbad_q  <= 1'b0;
					ts_q    <= `MEPP_TS_IDLE;
					nib_q   <= `MEPP_RST_NIB;
					en_q    <= 1'b0;
					er_q    <= 1'b0;
				end else begin
					hfull_q <= hfull_d;
					// One-byte holding stage is the only back-pressure
					ready_q <= ~hfull_d;
					if (take) begin
						hold_q <= txb_in[i*8 +: 8];
						hbad_q <= txe_in[i];
					end
					if (tx_rise) begin
						case (ts_q)
						`MEPP_TS_IDLE, `MEPP_TS_HIGH: begin
							if (hfull_q) begin
								nib_q  <= hold_q[3:0];
								hi_q   <= hold_q[7:4];
								cbad_q <= hbad_q;
								er_q   <= hbad_q;
								en_q   <= 1'b1;
								ts_q   <= `MEPP_TS_LOW;
							end else begin
								nib_q <= `MEPP_RST_NIB;
								en_q  <= 1'b0;
								er_q  <= 1'b0;
								ts_q  <= `MEPP_TS_IDLE;
							end
						end
						`MEPP_TS_LOW: begin
							nib_q <= hi_q;
							er_q  <= cbad_q;
							en_q  <= 1'b1;
							ts_q  <= `MEPP_TS_HIGH;
						end
						default: begin
							en_q <= 1'b0;
							er_q <= 1'b0;
							ts_q <= `MEPP_TS_IDLE;
						end
						endcase
					end
				end
			end
		end
	endgenerate

	assign eth0_tx_nibble     = g_ch[0].nib_q;
	assign eth0_tx_enable     = g_ch[0].en_q;
	assign eth0_tx_code_error = g_ch[0].er_q;
	assign eth0_tx_byte_ready = g_ch[0].ready_q;
	assign eth0_rx_byte       = g_ch[0].byte_q;
	assign eth0_rx_byte_valid = g_ch[0].bvalid_q;
	assign eth0_rx_frame_end  = g_ch[0].end_q;
	assign eth0_rx_frame_bad  = g_ch[0].fbad_q;
	assign eth0_collision     = g_ch[0].col_q;
	assign eth0_carrier       = g_ch[0].crs_q;
	assign eth1_tx_nibble     = g_ch[1].nib_q;
	assign eth1_tx_enable     = g_ch[1].en_q;
	assign eth1_tx_code_error = g_ch[1].er_q;
	assign eth1_tx_byte_ready = g_ch[1].ready_q;
	assign eth1_rx_byte       = g_ch[1].byte_q;
	assign eth1_rx_byte_valid = g_ch[1].bvalid_q;
	assign eth1_rx_frame_end  = g_ch[1].end_q;
	assign eth1_rx_frame_bad  = g_ch[1].fbad_q;
	assign eth1_collision     = g_ch[1].col_q;
	assign eth1_carrier       = g_ch[1].crs_q;

	////////////////////////////////////////////////////////////////////////
	// PHY management port
	wire        mdi_s;
	wire        tick;
	wire [5:0]  nb;
	wire [31:0] half_last;
	reg  [1:0]  ms_q;
	reg  [3:0]  div_q;
	reg         mdc_q, mdo_q, oe_n_q, rd_q, busy_q, done_q;
	reg  [5:0]  bit_q;
	reg  [31:0] word_q;
	reg  [15:0] rdata_q;

	mepp_sync #(
		.W(1)
	) u_mdi_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.d_in    (phy_mgmt_data_in),
		.q_out   (mdi_s)
	);

	assign half_last = `MEPP_MDC_HALF_CYC - 1;
	assign tick      = (div_q == half_last[3:0]);
	assign nb   = bit_q + 6'h01;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ms_q    <= `MEPP_MS_IDLE;
			div_q   <= 4'h0;
			mdc_q   <= 1'b0;
			mdo_q   <= `MEPP_RST_MDO;
			oe_n_q  <= 1'b1;
			rd_q    <= 1'b0;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			bit_q   <= 6'h00;
			word_q  <= 32'h00000000;
			rdata_q <= `MEPP_RST_WORD16;
		end else begin
			done_q <= 1'b0;
			case (ms_q)
			`MEPP_MS_IDLE: begin
				mdc_q  <= 1'b0;
				div_q  <= 4'h0;
				if (mgmt_start) begin
					word_q <= {`MEPP_MG_START,
						mgmt_read ? `MEPP_MG_OP_READ : `MEPP_MG_OP_WRITE,
						mgmt_phy_addr, mgmt_reg_addr, `MEPP_MG_TURN,
						mgmt_read ? `MEPP_RST_WORD16 : mgmt_wdata};
					rd_q   <= mgmt_read;
					bit_q  <= 6'h00;
					busy_q <= 1'b1;
					mdo_q  <= 1'b1;
					oe_n_q <= 1'b0;
					ms_q   <= `MEPP_MS_RUN;
				end
			end
			`MEPP_MS_RUN: begin
				div_q <= tick ? 4'h0 : div_q + 4'h1;
				if (tick) begin
					if (!mdc_q) begin
						mdc_q <= 1'b1;
						if (rd_q && bit_q >= `MEPP_MG_DATA_BIT)
							rdata_q <= {rdata_q[14:0], mdi_s};
					end else begin
						mdc_q <= 1'b0;
						if (bit_q == `MEPP_MG_LAST_BIT) begin
							busy_q <= 1'b0;
							done_q <= 1'b1;
							oe_n_q <= 1'b1;
							mdo_q  <= `MEPP_RST_MDO;
							ms_q   <= `MEPP_MS_IDLE;
						end else begin
							bit_q <= nb;
							if (nb >= `MEPP_MG_PRE_BITS) begin
								mdo_q  <= word_q[31];
								word_q <= {word_q[30:0], 1'b0};
							end
							// Release the line for the PHY's turnaround
							oe_n_q <= rd_q && (nb >= `MEPP_MG_TA_BIT);
						end
					end
				end
			end
			default: begin
				busy_q <= 1'b0;
				oe_n_q <= 1'b1;
				ms_q   <= `MEPP_MS_IDLE;
			end
			endcase
		end
	end

	assign phy_mgmt_clock     = mdc_q;
	assign phy_mgmt_data_out  = mdo_q;
	assign phy_mgmt_data_oe_n = oe_n_q;
	assign mgmt_busy          = busy_q;
	assign mgmt_done          = done_q;
	assign mgmt_rdata         = rdata_q;

endmodule // mepp_top

`default_nettype wire

// file: test/mepp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mepp_checker (
	input wire logic       clk_sys,
	input wire logic       reset_n,
	input wire logic       eth0_collision_in,
	input wire logic       eth0_collision,
	input wire logic       eth0_carrier_in,
	input wire logic       eth0_carrier,
	input wire logic       eth0_rx_valid,
	input wire logic       eth0_rx_frame_end,
	input wire logic [3:0] eth0_tx_nibble,
	input wire logic       eth0_tx_enable,
	input wire logic       phy_mgmt_clock,
	input wire logic       mgmt_busy,
	input wire logic       mgmt_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	property p_col;
		eth0_collision_in [*7] |-> eth0_collision;
	endproperty
	a_col: assert property (p_col) else $error("collision lost");
	property p_crs;
		eth0_carrier_in [*7] |-> eth0_carrier;
	endproperty
	a_crs: assert property (p_crs) else $error("carrier lost");
	// A direct path would let the output rise with the pin
	property p_sync;
		$rose(eth0_collision) |-> $past(eth0_collision_in, 2);
	endproperty
	a_sync: assert property (p_sync) else $error("no synchroniser");
	property p_idle;
		!eth0_tx_enable |-> eth0_tx_nibble == 4'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("idle nibble");
	property p_stand;
		$changed(eth0_tx_nibble) |=> $stable(eth0_tx_nibble) [*6];
	endproperty
	a_stand: assert property (p_stand) else $error("short nibble");
	property p_fend;
		$fell(eth0_rx_valid) |-> ##[4:16] eth0_rx_frame_end;
	endproperty
	a_fend: assert property (p_fend) else $error("no frame end");
	property p_half;
		$rose(phy_mgmt_clock) |=> phy_mgmt_clock [*3] ##1 !phy_mgmt_clock;
	endproperty
	a_half: assert property (p_half) else $error("mgmt clock");
	property p_len;
		$rose(mgmt_busy) |-> ##[508:516] mgmt_done;
	endproperty
	a_len: assert property (p_len) else $error("mgmt length");
endmodule // mepp_checker
bind mepp_top mepp_checker i_chk (.*);
`default_nettype wire

// file: test/mepp_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module mepp_phy_model #(
	parameter PH = 0
) (
	output var logic        rx_clock,
	output var logic        tx_clock,
	output var logic [3:0]  rx_nibble,
	output var logic        rx_valid,
	output var logic        rx_error,
	output wire logic       carrier,
	input  wire logic [3:0] tx_nibble,
	input  wire logic       tx_enable,
	input  wire logic       tx_code_error
);
	logic [5:0] nq[$];
	logic [8:0] got[$];
	logic [3:0] lo;
	logic       hi_q;
	// free-running clocks, below half of clk_sys
	initial begin
		{rx_clock, tx_clock, rx_valid, rx_error, hi_q} = 5'h00;
		rx_nibble = 4'h0;
		fork
			#(PH) forever #400 rx_clock = ~rx_clock;
			#(PH + 170) forever #400 tx_clock = ~tx_clock;
		join
	end
	assign carrier = rx_valid | tx_enable;
	function void push(input logic [7:0] b, input logic e, input logic v);
		nq.push_back({e, v, b[3:0]});
		nq.push_back({e, v, b[7:4]});
	endfunction
	// one nibble per clock; idle bus toggles
	always @(posedge rx_clock)
		if (nq.size() > 0) {rx_error, rx_valid, rx_nibble} <= nq.pop_front();
		else {rx_error, rx_valid, rx_nibble} <= {2'h0, ~rx_nibble};
	always @(posedge tx_clock) begin
		hi_q <= tx_enable & ~hi_q;
		lo <= tx_nibble;
		if (tx_enable & hi_q) got.push_back({tx_code_error, tx_nibble, lo});
	end
endmodule // mepp_phy_model
////////////////////////////////////////////////////////////////////////////
module mepp_mdio_model (
	input  wire logic mdc,
	input  wire logic out,
	input  wire logic oe_n,
	output wire logic din
);
	logic [5:0]  n = 6'h00;
	logic [31:0] sh;
	logic [15:0] rd = 16'h0000;
	// Frames are always 64 clocks, so the counter just wraps
	always @(posedge mdc) begin
		n <= n + 6'h01;
		sh <= {sh[30:0], out};
	end
	// read data from bit 48; pull-up otherwise
	assign din = !oe_n ? out : (n >= 6'h30 ? rd[6'h3f - n] : 1'b1);
endmodule // mepp_mdio_model
`default_nettype wire

// file: test/test_mepp_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_mepp_top;
	logic clk_sys, reset_n, mgmt_start, mgmt_read, mgmt_busy, mgmt_done;
	logic phy_mgmt_clock, phy_mgmt_data_in, phy_mgmt_data_out;
	logic phy_mgmt_data_oe_n;
	logic [4:0] mgmt_phy_addr, mgmt_reg_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata;
	logic eth0_collision_in, eth0_carrier_in, eth0_rx_clock, eth0_rx_valid;
	logic eth0_rx_error, eth0_tx_clock, eth0_tx_enable, eth0_tx_code_error;
	logic eth0_rx_byte_valid, eth0_rx_frame_end, eth0_rx_frame_bad;
	logic eth0_tx_byte_valid, eth0_tx_byte_bad, eth0_tx_byte_ready;
	logic eth0_collision, eth0_carrier;
	logic [3:0] eth0_rx_nibble, eth0_tx_nibble;
	logic [7:0] eth0_rx_byte, eth0_tx_byte;
	logic eth1_collision_in, eth1_carrier_in, eth1_rx_clock, eth1_rx_valid;
	logic eth1_rx_error, eth1_tx_clock, eth1_tx_enable, eth1_tx_code_error;
	logic eth1_rx_byte_valid, eth1_rx_frame_end, eth1_rx_frame_bad;
	logic eth1_tx_byte_valid, eth1_tx_byte_bad, eth1_tx_byte_ready;
	logic eth1_collision, eth1_carrier;
	logic [3:0] eth1_rx_nibble, eth1_tx_nibble;
	logic [7:0] eth1_rx_byte, eth1_tx_byte;
	logic [8:0] q_rx0[$], q_rx1[$], q_fb0[$], q_fb1[$], q_tx0[$], q_tx1[$];
	logic [31:0] q_md[$];
	int error_cnt = 0;
	int tests_run = 0;
	mepp_top i_dut (.*);
	mepp_phy_model #(.PH(13)) i_phy0 (.rx_clock(eth0_rx_clock),
		.tx_clock(eth0_tx_clock), .rx_nibble(eth0_rx_nibble),
		.rx_valid(eth0_rx_valid), .rx_error(eth0_rx_error),
		.carrier(eth0_carrier_in), .tx_nibble(eth0_tx_nibble),
		.tx_enable(eth0_tx_enable), .tx_code_error(eth0_tx_code_error));
	mepp_phy_model #(.PH(237)) i_phy1 (.rx_clock(eth1_rx_clock),
		.tx_clock(eth1_tx_clock), .rx_nibble(eth1_rx_nibble),
		.rx_valid(eth1_rx_valid), .rx_error(eth1_rx_error),
		.carrier(eth1_carrier_in), .tx_nibble(eth1_tx_nibble),
		.tx_enable(eth1_tx_enable), .tx_code_error(eth1_tx_code_error));
	mepp_mdio_model i_mdio (.mdc(phy_mgmt_clock), .out(phy_mgmt_data_out),
		.oe_n(phy_mgmt_data_oe_n), .din(phy_mgmt_data_in));
	////////////////////////////////////////////////////////////////////////
	task chk_byte(input logic [8:0] g, input logic [8:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_word(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wrap_up;
		if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rx_frame(input int n, input int bad, input bit pre);
		logic [7:0] b;
		// Error with valid low must not spoil the frame
		if (pre) i_phy0.push(8'hff, 1'b1, 1'b0);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			i_phy0.push(b, i == bad, 1'b1);
			q_rx0.push_back({1'b0, b});
			b = 8'($urandom);
			i_phy1.push(b, 1'b0, 1'b1);
			q_rx1.push_back({1'b0, b});
		end
		q_fb0.push_back({8'h0, bad < n});
		q_fb1.push_back(9'h0);
		while (q_fb0.size() + q_fb1.size() > 0) @(posedge clk_sys);
	endtask
	task automatic tx_byte(input int c, input logic [7:0] b, input logic e);
		if (c == 1) {eth1_tx_byte_valid, eth1_tx_byte, eth1_tx_byte_bad} <= {1'b1, b, e};
		else {eth0_tx_byte_valid, eth0_tx_byte, eth0_tx_byte_bad} <= {1'b1, b, e};
		if (c == 1) q_tx1.push_back({e, b});
		else q_tx0.push_back({e, b});
		do @(posedge clk_sys);
		while ((c == 1 ? eth1_tx_byte_ready : eth0_tx_byte_ready) !== 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		if (eth0_rx_byte_valid === 1'b1)
			chk_byte({1'b0, eth0_rx_byte}, q_rx0.pop_front());
		if (eth1_rx_byte_valid === 1'b1)
			chk_byte({1'b0, eth1_rx_byte}, q_rx1.pop_front());
		if (eth0_rx_byte_valid === 1'b1)
			chk_byte({8'h0, eth0_carrier}, 9'h001);
		if (eth1_rx_byte_valid === 1'b1)
			chk_byte({8'h0, eth1_carrier}, 9'h001);
		if (eth0_rx_frame_end === 1'b1)
			chk_byte({8'h0, eth0_rx_frame_bad}, q_fb0.pop_front());
		if (eth1_rx_frame_end === 1'b1)
			chk_byte({8'h0, eth1_rx_frame_bad}, q_fb1.pop_front());
		if (i_phy0.got.size() > 0)
			chk_byte(i_phy0.got.pop_front(), q_tx0.pop_front());
		if (i_phy1.got.size() > 0)
			chk_byte(i_phy1.got.pop_front(), q_tx1.pop_front());
		if (mgmt_done === 1'b1)
			chk_word(mgmt_read ? {16'h0, mgmt_rdata} : i_mdio.sh,
				q_md.pop_front());
	end
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Whole run needs under two thousand cycles
	initial begin
		#2000000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		{reset_n, mgmt_start, mgmt_read, mgmt_phy_addr, mgmt_reg_addr} = '0;
		{mgmt_wdata, eth0_collision_in, eth1_collision_in} = '0;
		{eth0_tx_byte_valid, eth0_tx_byte_bad, eth0_tx_byte} = '0;
		{eth1_tx_byte_valid, eth1_tx_byte_bad, eth1_tx_byte} = '0;
		void'($urandom(32'hf875));
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		for (int f = 0; f < 4; f++)
			rx_frame(f + 1, f == 2 ? 1 : 9, f == 1);
		for (int v = 1; v >= 0; v--) begin
			eth0_collision_in <= v[0];
			eth1_collision_in <= ~v[0];
			repeat (8) @(posedge clk_sys);
			chk_byte({7'h0, eth1_collision, eth0_collision},
				{7'h0, ~v[0], v[0]});
		end
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 5; i++)
				tx_byte(c, 8'($urandom), i == 3);
			if (c == 1) eth1_tx_byte_valid <= 1'b0;
			else eth0_tx_byte_valid <= 1'b0;
		end
		while (q_tx0.size() + q_tx1.size() > 0) @(posedge clk_sys);
		for (int k = 0; k < 2; k++) begin
			i_mdio.rd <= 16'($urandom);
			{mgmt_phy_addr, mgmt_reg_addr, mgmt_wdata} <= 26'($urandom);
			{mgmt_start, mgmt_read} <= {1'b1, k[0]};
			@(posedge clk_sys);
			mgmt_start <= 1'b0;
			q_md.push_back(k == 1 ? {16'h0, i_mdio.rd} : {4'h5,
				mgmt_phy_addr, mgmt_reg_addr, 2'h2, mgmt_wdata});
			while (q_md.size() > 0) @(posedge clk_sys);
		end
		wrap_up;
	end
endmodule // test_mepp_top
`default_nettype wire
